/* File: logic/gpf_map.vh */
// Purpose: Register offsets, field positions and reset values for the pin function block.
// Assumes: Included by the pin function design file only.
// Notes: Offsets are the device's register addresses on the plain register port.
`ifndef GPF_MAP_VH
`define GPF_MAP_VH

`define GPF_ADDR_W 8
`define GPF_OFS_PIN_FUNC 8'h27
`define GPF_OFS_PIN_STATE 8'h28
`define GPF_OFS_THERMAL 8'h29
`define GPF_OFS_GPO_EN 8'h2A
`define GPF_OFS_IRQ_STAT 8'h2B
`define GPF_OFS_IRQ_MASK 8'h2C

`define GPF_RST_PIN_FUNC 8'h00
`define GPF_RST_PIN_STATE 4'h0
`define GPF_RST_THERMAL 1'b0
`define GPF_RST_GPO_EN 4'h0
`define GPF_RST_IRQ 2'h0

`define GPF_FLD_ALERT_EN 0
`define GPF_FLD_BUSY_EN 1
`define GPF_FLD_LANE_LO 2
`define GPF_FLD_LANE_HI 3
`define GPF_FLD_ALERT_SEL 4
`define GPF_FLD_BUSY_SEL 5
`define GPF_FLD_OV_ALT_MODE 7
`define GPF_PIN_FUNC_WMASK 8'hBF

`define GPF_LANE_ONE 2'h0
`define GPF_LANE_TWO 2'h1
`define GPF_LANE_PKG 2'h2
`define GPF_LANE_ONE_ALT 2'h3

`define GPF_LANES_1 3'h1
`define GPF_LANES_2 3'h2
`define GPF_LANES_4 3'h4

`define GPF_PIN_SHARED0 0
`define GPF_PIN_TWO 2
`define GPF_PIN_THREE 3

`endif

/* File: logic/gpf_pin_function.v */
// Purpose: Pin function control, pin state and thermal include registers of the converter.
// Assumes: One clock; register port with read data one cycle after the read strobe.
// Notes: Higher priority pin owners arrive on hi_prio_own_i from the arbitration logic.
//
// Overview of operation
// - Lane select code 0 gives one output lane, code 1 gives two lanes and code 11 gives one lane.
// - Lane code 10 (field value 2) gives one lane on the leaded package and four on wafer-level.
// - With busy enable set and no higher owner, the busy indicator goes to the chosen busy pin.
// - With alert enable set, no higher owner and no busy indicator on that pin, the alert indicator goes to the chosen alert pin.
// - Pin state bits 7:4 are read-only and show the levels of pins configured as inputs.
// - On the leaded package the upper three input level bits always read as zero.
// - Pin state bits 3:0 are writable and set the level of pins configured as outputs.
// - Upper three output level bits act only on wafer-level; on leaded they drive no pin.
// - With a sequencer active and the thermal include bit set, the sensor joins the sequence.
// - Pin state and thermal control registers reset to zero; thermal bits 7:1 read zero.
// - Lane select occupies bits 3:2 of the pin function register, read-write, reset zero.
// - Busy choice 0 uses shared pin zero, 1 uses general pin three, the latter on wafer-level only.
// - Alert choice 0 uses shared pin zero, 1 uses general pin two, the latter on wafer-level only.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "gpf_map.vh"

module gpf_pin_function (
  // Clock and reset.
  input wire clk_sys_i,
  input wire rst_b_i,
  // Register port.
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Package strap, high on the wafer-level package.
  input wire pkg_wafer_i,
  // Internal indicators and sequencer state.
  input wire conv_busy_i,
  input wire alert_i,
  input wire seq_active_i,
  input wire [3:0] hi_prio_own_i,
  // Pins.
  input wire [3:0] gp_pin_i,
  output reg [3:0] gp_pin_o,
  output reg [3:0] gp_pin_oe_o,
  // Status toward the rest of the device.
  output reg [2:0] sdo_lanes_o,
  output reg temp_in_seq_o,
  output reg ov_alt_mode_o,
  output reg irq_o
);

  reg [7:0] pin_func_r;
  reg [3:0] out_level_r;
  reg thermal_en_r;
  reg [3:0] gpo_en_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg [3:0] pin_meta_r;
  reg [3:0] pin_sync_r;
  reg [3:0] in_level_r;
  reg pkg_wafer_r;
  reg pkg_captured_r;
  reg pkg_meta_r;
  reg pkg_sync_r;
  reg [1:0] pkg_step_r;
  reg [1:0] irq_stat_nxt;
  reg busy_d_r;
  reg alert_d_r;
  reg [7:0] rdata_nxt;
  reg [2:0] lanes_nxt;
  reg [3:0] pin_nxt;
  reg [3:0] oe_nxt;
  reg [3:0] in_mask;
  reg [3:0] busy_route;
  reg [3:0] alert_route;
  wire [1:0] lane_code;
  wire [1:0] irq_event;
  reg wr_func;
  reg wr_state;
  reg wr_thermal;
  reg wr_gpo_en;
  reg wr_stat;
  reg wr_mask;

  assign lane_code = pin_func_r[`GPF_FLD_LANE_HI:`GPF_FLD_LANE_LO];

  // One strobe per register; an unmapped address selects nothing, so the write is dropped.
  always @* begin
    wr_func = 1'b0;
    wr_state = 1'b0;
    wr_thermal = 1'b0;
    wr_gpo_en = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `GPF_OFS_PIN_FUNC: wr_func = 1'b1;
        `GPF_OFS_PIN_STATE: wr_state = 1'b1;
        `GPF_OFS_THERMAL: wr_thermal = 1'b1;
        `GPF_OFS_GPO_EN: wr_gpo_en = 1'b1;
        `GPF_OFS_IRQ_STAT: wr_stat = 1'b1;
        `GPF_OFS_IRQ_MASK: wr_mask = 1'b1;
        default: wr_func = 1'b0;
      endcase
    end
  end

  // Events: bit 0 busy rising edge, bit 1 alert rising edge.
  assign irq_event = {alert_i & ~alert_d_r, conv_busy_i & ~busy_d_r};

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and package strap capture.

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= gp_pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pkg_meta_r <= 1'b0;
      pkg_sync_r <= 1'b0;
      pkg_step_r <= 2'h0;
      pkg_wafer_r <= 1'b0;
      pkg_captured_r <= 1'b0;
    end else begin
      pkg_meta_r <= pkg_wafer_i;
      pkg_sync_r <= pkg_meta_r;
      // The strap is taken once, after it has crossed both flops, and then held.
      // Until then the leaded behaviour applies, which never drives the wafer-only pins.
      if (!pkg_captured_r) begin
        if (pkg_step_r == 2'h2) begin
          pkg_wafer_r <= pkg_sync_r;
          pkg_captured_r <= 1'b1;
        end else begin
          pkg_step_r <= pkg_step_r + 2'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_func_r <= `GPF_RST_PIN_FUNC;
    end else if (wr_func) begin
      // Bit 6 is reserved and is always stored as zero.
      pin_func_r <= reg_wdata_i & `GPF_PIN_FUNC_WMASK;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_level_r <= `GPF_RST_PIN_STATE;
    end else if (wr_state) begin
      out_level_r <= reg_wdata_i[3:0];
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      thermal_en_r <= `GPF_RST_THERMAL;
    end else if (wr_thermal) begin
      thermal_en_r <= reg_wdata_i[0];
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gpo_en_r <= `GPF_RST_GPO_EN;
    end else if (wr_gpo_en) begin
      gpo_en_r <= reg_wdata_i[3:0];
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask_r <= `GPF_RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_r <= reg_wdata_i[1:0];
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_d_r <= 1'b0;
      alert_d_r <= 1'b0;
    end else begin
      busy_d_r <= conv_busy_i;
      alert_d_r <= alert_i;
    end
  end

  // The set term comes after the clear, so an event that meets a clear still lands.
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (wr_stat) begin
      irq_stat_nxt = irq_stat_nxt & ~reg_wdata_i[1:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_event;
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_r <= `GPF_RST_IRQ;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin ownership and drive.

  always @* begin
    busy_route = 4'h0;
    alert_route = 4'h0;
    if (pin_func_r[`GPF_FLD_BUSY_EN]) begin
      if (pkg_wafer_r && pin_func_r[`GPF_FLD_BUSY_SEL]) begin
        busy_route[`GPF_PIN_THREE] = 1'b1;
      end else begin
        busy_route[`GPF_PIN_SHARED0] = 1'b1;
      end
    end
    if (pin_func_r[`GPF_FLD_ALERT_EN]) begin
      if (pkg_wafer_r && pin_func_r[`GPF_FLD_ALERT_SEL]) begin
        alert_route[`GPF_PIN_TWO] = 1'b1;
      end else begin
        alert_route[`GPF_PIN_SHARED0] = 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      wire wafer_ok;
      assign wafer_ok = (gi == 0) || pkg_wafer_r;
      always @* begin
        pin_nxt[gi] = 1'b0;
        oe_nxt[gi] = 1'b0;
        in_mask[gi] = 1'b0;
        if (hi_prio_own_i[gi]) begin
          oe_nxt[gi] = 1'b0;
        end else if (busy_route[gi]) begin
          pin_nxt[gi] = conv_busy_i;
          oe_nxt[gi] = 1'b1;
        end else if (alert_route[gi]) begin
          pin_nxt[gi] = alert_i;
          oe_nxt[gi] = 1'b1;
        end else if (gpo_en_r[gi] && wafer_ok) begin
          pin_nxt[gi] = out_level_r[gi];
          oe_nxt[gi] = 1'b1;
        end else begin
          in_mask[gi] = wafer_ok;
        end
      end
    end
  endgenerate

  always @* begin
    case (lane_code)
      `GPF_LANE_ONE: lanes_nxt = `GPF_LANES_1;
      `GPF_LANE_TWO: lanes_nxt = `GPF_LANES_2;
      `GPF_LANE_PKG: lanes_nxt = pkg_wafer_r ? `GPF_LANES_4 : `GPF_LANES_1;
      default: lanes_nxt = `GPF_LANES_1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux and registered outputs.

  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      `GPF_OFS_PIN_FUNC: rdata_nxt = pin_func_r;
      `GPF_OFS_PIN_STATE: rdata_nxt = {in_level_r, out_level_r};
      `GPF_OFS_THERMAL: rdata_nxt = {7'h00, thermal_en_r};
      `GPF_OFS_GPO_EN: rdata_nxt = {4'h0, gpo_en_r};
      `GPF_OFS_IRQ_STAT: rdata_nxt = {6'h00, irq_stat_r};
      `GPF_OFS_IRQ_MASK: rdata_nxt = {6'h00, irq_mask_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands in each cycle after one with the read strobe high and is zero otherwise.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_nxt : 8'h00;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_level_r <= 4'h0;
    end else begin
      in_level_r <= pin_sync_r & in_mask;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gp_pin_o <= 4'h0;
      gp_pin_oe_o <= 4'h0;
    end else begin
      gp_pin_o <= pin_nxt;
      gp_pin_oe_o <= oe_nxt;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sdo_lanes_o <= `GPF_LANES_1;
    end else begin
      sdo_lanes_o <= lanes_nxt;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      temp_in_seq_o <= 1'b0;
    end else begin
      temp_in_seq_o <= seq_active_i & thermal_en_r;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ov_alt_mode_o <= 1'b0;
    end else begin
      ov_alt_mode_o <= pin_func_r[`GPF_FLD_OV_ALT_MODE];
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule
`default_nettype wire

/* File: tb/gpf_chk.sv */
// Purpose: Port checker for the pin function block.
// Assumes: Strap stable while out of reset.
// Notes: Shadows control writes to predict pins and lane count.
`timescale 1ns/1ps
`default_nettype none
module gpf_chk (
  // Clock, reset and register port.
  input wire clk_sys_i, input wire rst_b_i, input wire reg_wr_i, input wire reg_rd_i,
  input wire [7:0] reg_addr_i, input wire [7:0] reg_wdata_i, input wire [7:0] reg_rdata_o,
  // Device side.
  input wire pkg_wafer_i, input wire conv_busy_i, input wire alert_i, input wire seq_active_i,
  input wire [3:0] hi_prio_own_i, input wire [3:0] gp_pin_o, input wire [3:0] gp_pin_oe_o,
  input wire [2:0] sdo_lanes_o, input wire temp_in_seq_o
);
  reg [7:0] pf_r;
  reg temp_r;
  wire [2:0] lanes_nxt;
  assign lanes_nxt = (pf_r[3:2] == 2'h1) ? 3'h2 : (pf_r[3:2] == 2'h2 && pkg_wafer_i) ? 3'h4 : 3'h1;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pf_r <= 8'h00;
      temp_r <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h27) pf_r <= reg_wdata_i;
      if (reg_addr_i == 8'h29) temp_r <= reg_wdata_i[0];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_rd(a); reg_rd_i && reg_addr_i == a ##1 1'b1; endsequence
  property p_lane; sdo_lanes_o == $past(lanes_nxt); endproperty
  a_lane: assert property (p_lane) else $error("lane count");
  property p_temp; temp_in_seq_o == ($past(temp_r) && $past(seq_active_i)); endproperty
  a_temp: assert property (p_temp) else $error("sensor include");
  property p_therm; s_rd(8'h29) |-> reg_rdata_o[7:1] == 7'h00; endproperty
  a_therm: assert property (p_therm) else $error("thermal reserved");
  property p_in_leaded; s_rd(8'h28) |-> pkg_wafer_i || reg_rdata_o[7:5] == 3'h0; endproperty
  a_in_leaded: assert property (p_in_leaded) else $error("input bits");
  property p_oe_leaded; !pkg_wafer_i |-> gp_pin_oe_o[3:1] == 3'h0; endproperty
  a_oe_leaded: assert property (p_oe_leaded) else $error("leaded drive");
  property p_prio; (gp_pin_oe_o & $past(hi_prio_own_i)) == 4'h0; endproperty
  a_prio: assert property (p_prio) else $error("owned pin driven");
  property p_busy;
    $past(pf_r[1] && !hi_prio_own_i[0] && !(pkg_wafer_i && pf_r[5]))
      |-> gp_pin_oe_o[0] && gp_pin_o[0] == $past(conv_busy_i);
  endproperty
  a_busy: assert property (p_busy) else $error("busy pin");
  property p_alert;
    $past(pkg_wafer_i && pf_r[0] && pf_r[4] && !hi_prio_own_i[2])
      |-> gp_pin_oe_o[2] && gp_pin_o[2] == $past(alert_i);
  endproperty
  a_alert: assert property (p_alert) else $error("alert pin");
  property p_busy3;
    $past(pkg_wafer_i && pf_r[1] && pf_r[5] && !hi_prio_own_i[3])
      |-> gp_pin_oe_o[3] && gp_pin_o[3] == $past(conv_busy_i);
  endproperty
  a_busy3: assert property (p_busy3) else $error("busy pin three");
endmodule
`default_nettype wire

/* File: tb/gpf_pin_load.sv */
// Purpose: Board load on the four pins.
// Assumes: Loads never fight a driven pin.
// Notes: A free pin shows the level the bench gives it.
`timescale 1ns/1ps
`default_nettype none
module gpf_pin_load (
  input wire [3:0] drv_lvl_i, input wire [3:0] drv_en_i, input wire [3:0] load_lvl_i,
  output wire [3:0] pin_lvl_o
);
  assign pin_lvl_o = (drv_en_i & drv_lvl_i) | (~drv_en_i & load_lvl_i);
endmodule
`default_nettype wire

/* File: tb/test_gp_pin_function_and_state.sv */
// Purpose: Self-checking bench for the pin function block.
// Assumes: Both package straps run in turn, each after a reset.
// Notes: Pin timing is judged by the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_gp_pin_function_and_state;
  reg clk_sys_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, pkg_wafer_i = 1'b0;
  reg conv_busy_i = 1'b0, alert_i = 1'b0, seq_active_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  reg [3:0] hi_prio_own_i = 4'h0, load_lvl = 4'h0, d, m;
  reg [31:0] r;
  wire [7:0] reg_rdata_o;
  wire [3:0] gp_pin_i, gp_pin_o, gp_pin_oe_o;
  wire [2:0] sdo_lanes_o;
  wire temp_in_seq_o, irq_o, ov_alt_mode_o;
  integer seed = 18808, fail_count = 0, checks = 0, cyc = 0, i, p;
  gpf_pin_function u_gpf_pin_function (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pkg_wafer_i, .conv_busy_i, .alert_i, .seq_active_i,
    .hi_prio_own_i, .gp_pin_i, .gp_pin_o, .gp_pin_oe_o, .sdo_lanes_o, .temp_in_seq_o,
    .ov_alt_mode_o, .irq_o);
  gpf_pin_load u_gpf_pin_load (.drv_lvl_i(gp_pin_o), .drv_en_i(gp_pin_oe_o),
    .load_lvl_i(load_lvl), .pin_lvl_o(gp_pin_i));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // A run far past the planned length means a hang.
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_sys_i);
      {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk_sys_i);
      {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, e);
    end
  endtask
  function [2:0] lanes(input [1:0] l, input w);
    lanes = (l == 2'h1) ? 3'h2 : (l == 2'h2 && w) ? 3'h4 : 3'h1;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    for (p = 0; p < 2; p = p + 1) begin
      rst_b_i <= 1'b0;
      pkg_wafer_i <= p[0];
      {conv_busy_i, alert_i, hi_prio_own_i, load_lvl} <= 10'h000;
      m = p[0] ? 4'hF : 4'h1;
      repeat (5) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      rd(8'h28, 8'h00);
      rd(8'h29, 8'h00);
      wr(8'h29, 8'hFF);
      rd(8'h29, 8'h01);
      seq_active_i <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        wr(8'h27, {4'h0, i[1:0], 2'h0});
        @(posedge clk_sys_i);
        #1 chk(sdo_lanes_o, lanes(i[1:0], p[0]));
        rd(8'h27, {4'h0, i[1:0], 2'h0});
      end
      chk(temp_in_seq_o, 1'b1);
      d = $random(seed);
      wr(8'h2A, 8'h0F);
      wr(8'h28, {4'h0, d});
      @(posedge clk_sys_i);
      #1 chk(gp_pin_oe_o, m);
      chk(gp_pin_o & m, d & m);
      wr(8'h2A, 8'h00);
      load_lvl <= $random(seed);
      repeat (5) @(posedge clk_sys_i);
      rd(8'h28, {load_lvl & m, d});
      rd(8'h50, 8'h00);
      wr(8'h27, 8'h33);
      for (i = 0; i < 80; i = i + 1) begin
        @(posedge clk_sys_i);
        r = $random(seed);
        {conv_busy_i, alert_i, hi_prio_own_i} <= {r[0], r[1] && i < 79, r[7:4] & r[11:8]};
      end
      wr(8'h2B, 8'h03);
      alert_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1 chk(irq_o, 1'b0);
      wr(8'h2C, 8'h02);
      @(posedge clk_sys_i);
      #1 chk(irq_o, 1'b1);
      wr(8'h2B, 8'h02);
      rd(8'h2B, 8'h00);
      chk(irq_o, 1'b0);
      wr(8'h2C, 8'h00);
      conv_busy_i <= 1'b0;
      wr(8'h2B, 8'h03);
      conv_busy_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rd(8'h2B, 8'h01);
      wr(8'h27, 8'hFF);
      rd(8'h27, 8'hBF);
      #1 chk(ov_alt_mode_o, 1'b1);
    end
    finish_test;
  end
endmodule
bind gpf_pin_function gpf_chk u_gpf_chk (.clk_sys_i, .rst_b_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .pkg_wafer_i, .conv_busy_i, .alert_i,
  .seq_active_i, .hi_prio_own_i, .gp_pin_o, .gp_pin_oe_o, .sdo_lanes_o, .temp_in_seq_o);
`default_nettype wire
